// [rtl/sadc_pkg.sv]
// Shared constants and state types for the serial converter link
package sadc_pkg;
    localparam int ADDR_BITS = 4;
    localparam int RES_BITS = 10;
    // Conversion length in conversion clock periods
    localparam logic [5:0] CONV_CYCLES = 6'h2c;
    // Transfer clock falls that open and close the sample window
    localparam logic [3:0] SAMPLE_FALL = 4'h4;
    localparam logic [3:0] HOLD_FALL = 4'ha;
    // Conversion clock rises seen before the arming fall
    localparam logic [1:0] ARM_RISES = 2'h2;
    localparam logic [3:0] SELF_TEST_CH = 4'hb;
    localparam logic [9:0] SELF_TEST_CODE = 10'h200;
    localparam logic [9:0] CODE_FULL = 10'h3ff;
    localparam logic [9:0] CODE_ZERO = 10'h000;
    localparam logic [9:0] SAR_TOP = 10'h200;
    localparam int CLK_PERIOD_NS = 50;
    localparam int XFER_HALF_NS = 500;
    localparam int XFER_HALF_CYC = (XFER_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [5:0] CS_SETUP_CONV = 6'h03;
    localparam logic [5:0] HOST_SETUP_EDGES = CS_SETUP_CONV + 6'h01;
    localparam logic [5:0] HOST_HOLD_EDGES = CONV_CYCLES + 6'h02;

    typedef enum logic [2:0] {
        DEV_OFF = 3'b001,
        DEV_ARM = 3'b010,
        DEV_XFER = 3'b100
    } sadc_dev_state_e;

    typedef enum logic [4:0] {
        HST_IDLE = 5'b00001,
        HST_SETUP = 5'b00010,
        HST_LOW = 5'b00100,
        HST_HIGH = 5'b01000,
        HST_WAIT = 5'b10000
    } sadc_hst_state_e;
endpackage : sadc_pkg

// [rtl/sadc_if.sv]
// Serial link between the converter end and the controlling host
interface sadc_if;
    logic cs_n;
    logic addr_bit;
    logic xfer_clk;
    logic conv_clk;
    logic dout;
    logic dout_oe;
    modport dev (input cs_n, input addr_bit, input xfer_clk, input conv_clk,
        output dout, output dout_oe);
    modport host (output cs_n, output addr_bit, output xfer_clk, input conv_clk,
        input dout);
endinterface : sadc_if

// [rtl/sadc_sync.sv]
// Two-stage synchroniser for a group of asynchronous inputs
module sadc_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic ce,
    // Data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } sadc_sync_s;

    sadc_sync_s s_reg;
    sadc_sync_s s_next;

    always_comb begin
        s_next = s_reg;
        for (int i = 0; i < W; i++) begin
            s_next.meta[i] = d[i];
            s_next.stable[i] = s_reg.meta[i];
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            s_reg <= '0;
        end else if (ce) begin
            s_reg <= s_next;
        end
    end

    assign q = s_reg.stable;
endmodule : sadc_sync

// [rtl/sadc_dev.sv]
// Converter end: select filtering, serial shifter, sampling and conversion
module sadc_dev (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic ce,
    // Serial link
    sadc_if.dev link,
    // Analog side: level of the selected channel, bit 11 means below zero
    input wire logic [11:0] ain_level,
    output logic [3:0] chan_sel,
    output logic sampling,
    // Conversion status
    output logic conv_busy,
    output logic [9:0] result
);
    import sadc_pkg::*;

    typedef struct packed {
        sadc_dev_state_e st;
        logic [1:0] rise_cnt;
        logic [3:0] rcnt;
        logic [3:0] fcnt;
        logic [3:0] addr_sr;
        logic [3:0] chan;
        logic [9:0] data_sr;
        logic dout;
        logic sampling;
        logic [9:0] held;
        logic busy;
        logic [5:0] ccnt;
        logic [9:0] sar;
        logic [9:0] result;
        logic cs_q;
        logic xclk_q;
        logic cclk_q;
    } sadc_dev_s;

    sadc_dev_s s_reg;
    sadc_dev_s s_next;
    logic [3:0] pins_s;
    logic cs_s;
    logic xclk_s;
    logic cclk_s;
    logic addr_s;

    // Every link pin arrives asynchronously, both clocks included
    sadc_sync #(.W(4)) u_sync (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .ce(ce),
        .d({link.cs_n, link.xfer_clk, link.conv_clk, link.addr_bit}),
        .q(pins_s)
    );

    assign cs_s = pins_s[3];
    assign xclk_s = pins_s[2];
    assign cclk_s = pins_s[1];
    assign addr_s = pins_s[0];

    always_comb begin
        logic c_rise;
        logic c_fall;
        logic x_rise;
        logic x_fall;
        logic cs_fall;
        logic conv_done;
        logic [9:0] trial;
        logic [9:0] level;
        c_rise = cclk_s & ~s_reg.cclk_q;
        c_fall = ~cclk_s & s_reg.cclk_q;
        x_rise = xclk_s & ~s_reg.xclk_q;
        x_fall = ~xclk_s & s_reg.xclk_q;
        cs_fall = ~cs_s & s_reg.cs_q;
        conv_done = 1'b0;
        trial = CODE_ZERO;
        level = CODE_ZERO;
        s_next = s_reg;
        s_next.cs_q = cs_s;
        s_next.xclk_q = xclk_s;
        s_next.cclk_q = cclk_s;

        // Level seen by the sampler
        if (s_reg.chan == SELF_TEST_CH) begin
            level = SELF_TEST_CODE;
        end else if (ain_level[11]) begin
            level = CODE_ZERO;
        end else if (ain_level[10]) begin
            level = CODE_FULL;
        end else begin
            level = ain_level[9:0];
        end

        // Successive approximation, one bit per conversion clock rise;
        // the remaining periods only pad out the fixed conversion length
        if (s_reg.busy && c_rise) begin
            if (s_reg.ccnt < 6'(RES_BITS)) begin
                trial = s_reg.sar | (SAR_TOP >> s_reg.ccnt);
                if (s_reg.held >= trial) begin
                    s_next.sar = trial;
                end
            end
            s_next.ccnt = s_reg.ccnt + 6'h01;
            if (s_reg.ccnt == CONV_CYCLES - 6'h01) begin
                s_next.busy = 1'b0;
                s_next.result = s_reg.sar;
                conv_done = 1'b1;
            end
        end

        case (s_reg.st)
            DEV_OFF: begin
                if (cs_fall) begin
                    s_next.st = DEV_ARM;
                    s_next.rise_cnt = 2'h0;
                end
            end
            DEV_ARM: begin
                if (cs_s) begin
                    s_next.st = DEV_OFF;
                end else begin
                    if (c_rise && s_reg.rise_cnt != ARM_RISES) begin
                        s_next.rise_cnt = s_reg.rise_cnt + 2'h1;
                    end
                    if (c_fall && s_reg.rise_cnt == ARM_RISES) begin
                        s_next.st = DEV_XFER;
                        s_next.rcnt = 4'h0;
                        s_next.fcnt = 4'h0;
                        s_next.sampling = 1'b0;
                        // Result finished in this very cycle still counts
                        s_next.data_sr = s_next.result;
                        s_next.dout = s_next.result[9];
                        // A conversion still running is lost
                        s_next.busy = 1'b0;
                        s_next.ccnt = 6'h00;
                    end
                end
            end
            DEV_XFER: begin
                if (cs_s) begin
                    // Sampling stops but a started conversion carries on
                    s_next.st = DEV_OFF;
                    s_next.sampling = 1'b0;
                end else begin
                    if (x_rise && s_reg.rcnt != SAMPLE_FALL) begin
                        s_next.addr_sr = {s_reg.addr_sr[2:0], addr_s};
                        s_next.rcnt = s_reg.rcnt + 4'h1;
                    end
                    if (x_fall) begin
                        s_next.fcnt = s_reg.fcnt + 4'h1;
                        s_next.data_sr = {s_reg.data_sr[8:0], 1'b0};
                        s_next.dout = s_reg.data_sr[8];
                        if (s_reg.fcnt == SAMPLE_FALL - 4'h1) begin
                            s_next.chan = s_reg.addr_sr;
                            s_next.sampling = 1'b1;
                        end
                        if (s_reg.fcnt == HOLD_FALL - 4'h1) begin
                            s_next.sampling = 1'b0;
                            s_next.held = level;
                            s_next.busy = 1'b1;
                            s_next.ccnt = 6'h00;
                            s_next.sar = CODE_ZERO;
                            s_next.fcnt = 4'h0;
                            s_next.rcnt = 4'h0;
                            // Last completed result is offered next
                            s_next.data_sr = s_next.result;
                            s_next.dout = s_next.result[9];
                        end
                    end else if (conv_done && s_reg.fcnt == 4'h0 && s_reg.rcnt == 4'h0) begin
                        // Select held low: present the fresh result
                        s_next.data_sr = s_next.result;
                        s_next.dout = s_next.result[9];
                    end
                end
            end
            default: begin
                s_next.st = DEV_OFF;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            s_reg <= '0;
            s_reg.st <= DEV_OFF;
            s_reg.cs_q <= 1'b1;
        end else if (ce) begin
            s_reg <= s_next;
        end
    end

    assign link.dout = s_reg.dout;
    assign link.dout_oe = (s_reg.st == DEV_XFER);
    assign chan_sel = s_reg.chan;
    assign sampling = s_reg.sampling;
    assign conv_busy = s_reg.busy;
    assign result = s_reg.result;
endmodule : sadc_dev

// [rtl/sadc_host.sv]
// Host end: runs one address and readout sequence per start request
module sadc_host (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic ce,
    // Serial link
    sadc_if.host link,
    // User request
    input wire logic start,
    input wire logic [3:0] start_addr,
    output logic busy,
    // Readout of the previous conversion
    output logic [9:0] rd_data,
    output logic rd_valid
);
    import sadc_pkg::*;

    typedef struct packed {
        sadc_hst_state_e st;
        logic [3:0] div;
        logic [3:0] bit_idx;
        logic [5:0] edges;
        logic [3:0] addr_sr;
        logic [9:0] rd_sr;
        logic [9:0] rd_data;
        logic rd_valid;
        logic cs_n;
        logic xclk;
        logic addr_bit;
        logic cclk_q;
    } sadc_hst_s;

    sadc_hst_s s_reg;
    sadc_hst_s s_next;
    logic [1:0] pins_s;

    sadc_sync #(.W(2)) u_sync (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .ce(ce),
        .d({link.dout, link.conv_clk}),
        .q(pins_s)
    );

    always_comb begin
        logic c_rise;
        logic half_done;
        c_rise = pins_s[0] & ~s_reg.cclk_q;
        half_done = (s_reg.div == 4'(XFER_HALF_CYC - 1));
        s_next = s_reg;
        s_next.cclk_q = pins_s[0];
        s_next.rd_valid = 1'b0;
        if (c_rise && s_reg.edges != 6'h3f) begin
            s_next.edges = s_reg.edges + 6'h01;
        end
        case (s_reg.st)
            HST_IDLE: begin
                if (start) begin
                    s_next.st = HST_SETUP;
                    s_next.cs_n = 1'b0;
                    s_next.edges = 6'h00;
                    s_next.addr_sr = start_addr;
                    s_next.bit_idx = 4'h0;
                end
            end
            HST_SETUP: begin
                // One spare period covers the select filter's lag
                if (s_reg.edges >= HOST_SETUP_EDGES) begin
                    s_next.st = HST_LOW;
                    s_next.div = 4'h0;
                    s_next.addr_bit = s_reg.addr_sr[3];
                end
            end
            HST_LOW: begin
                s_next.div = s_reg.div + 4'h1;
                if (half_done) begin
                    s_next.st = HST_HIGH;
                    s_next.div = 4'h0;
                    s_next.xclk = 1'b1;
                end
            end
            HST_HIGH: begin
                s_next.div = s_reg.div + 4'h1;
                if (half_done) begin
                    s_next.div = 4'h0;
                    s_next.xclk = 1'b0;
                    s_next.rd_sr = {s_reg.rd_sr[8:0], pins_s[1]};
                    s_next.addr_sr = {s_reg.addr_sr[2:0], 1'b0};
                    s_next.addr_bit = s_reg.addr_sr[2];
                    s_next.bit_idx = s_reg.bit_idx + 4'h1;
                    s_next.st = HST_LOW;
                    if (s_reg.bit_idx == HOLD_FALL - 4'h1) begin
                        s_next.st = HST_WAIT;
                        s_next.edges = 6'h00;
                        s_next.addr_bit = 1'b0;
                    end
                end
            end
            HST_WAIT: begin
                // Select rises two cycles after the tenth fall, so the converter
                // sees that fall while still selected and starts its conversion
                s_next.div = s_reg.div + 4'h1;
                if (s_reg.div == 4'h1) begin
                    s_next.cs_n = 1'b1;
                end
                if (s_reg.edges >= HOST_HOLD_EDGES) begin
                    s_next.st = HST_IDLE;
                    s_next.rd_data = s_reg.rd_sr;
                    s_next.rd_valid = 1'b1;
                end
            end
            default: begin
                s_next.st = HST_IDLE;
                s_next.cs_n = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            s_reg <= '0;
            s_reg.st <= HST_IDLE;
            s_reg.cs_n <= 1'b1;
        end else if (ce) begin
            s_reg <= s_next;
        end
    end

    assign link.cs_n = s_reg.cs_n;
    assign link.xfer_clk = s_reg.xclk;
    assign link.addr_bit = s_reg.addr_bit;
    assign busy = (s_reg.st != HST_IDLE);
    assign rd_data = s_reg.rd_data;
    assign rd_valid = s_reg.rd_valid;
endmodule : sadc_host

// [verification/sadc_asserts.sv]
// Concurrent checks on the serial link between host and converter
module sadc_asserts (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Link
    input wire logic cs_n,
    input wire logic addr_bit,
    input wire logic xfer_clk,
    input wire logic conv_clk,
    input wire logic dout,
    input wire logic dout_oe
);
    // Select must stay high for 44 conversion periods of 8 clk_sys each
    localparam int HI_MIN = 352;
    localparam int SETUP_MIN = 24;
    logic [11:0] hi_cnt_reg;
    logic [11:0] lo_cnt_reg;
    logic [3:0] rise_cnt_reg;
    logic xf_reg;
    logic cc_reg;
    logic [7:0] cc_hi_reg;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    // Starts saturated so the first select after reset is not flagged
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            hi_cnt_reg <= 12'h0fff;
            lo_cnt_reg <= 12'h0000;
            rise_cnt_reg <= 4'h0;
            xf_reg <= 1'b0;
            cc_reg <= 1'b0;
            cc_hi_reg <= 8'hff;
        end else begin
            xf_reg <= xfer_clk;
            cc_reg <= conv_clk;
            if (!cs_n) cc_hi_reg <= 8'h00;
            else if (conv_clk && !cc_reg && cc_hi_reg != 8'hff) cc_hi_reg <= cc_hi_reg + 8'h01;
            if (!cs_n) hi_cnt_reg <= 12'h0000;
            else if (hi_cnt_reg != 12'h0fff) hi_cnt_reg <= hi_cnt_reg + 12'h0001;
            if (cs_n) lo_cnt_reg <= 12'h0000;
            else if (lo_cnt_reg != 12'h0fff) lo_cnt_reg <= lo_cnt_reg + 12'h0001;
            if (hi_cnt_reg != 12'h0000) rise_cnt_reg <= 4'h0;
            else if (xfer_clk && !xf_reg) rise_cnt_reg <= rise_cnt_reg + 4'h1;
        end
    end

    sequence s_recog;
        ##[1:40] dout_oe;
    endsequence

    AST_DESEL_OFF: assert property (cs_n [*8] |-> !dout_oe)
        else $error("output enabled while deselected");
    AST_DESEL_QUIET: assert property (cs_n |-> !xfer_clk)
        else $error("transfer clock high while deselected");
    AST_OE_DROP: assert property ($rose(cs_n) |-> ##[1:8] !dout_oe)
        else $error("output not released after deselect");
    AST_RECOG_LATE: assert property ($fell(cs_n) |-> !dout_oe [*8])
        else $error("select recognised too early");
    AST_RECOG_BOUND: assert property ($fell(cs_n) |-> s_recog)
        else $error("select not recognised in time");
    AST_DOUT_STEADY: assert property (dout_oe && $past(dout_oe) && xfer_clk && $past(xfer_clk)
        |-> $stable(dout))
        else $error("data changed during high half");
    AST_SHIFT_LATE: assert property ($fell(xfer_clk) && dout_oe |=> $stable(dout))
        else $error("data shifted before fall was seen");
    AST_TEN_CYCLES: assert property ($rose(cs_n) |-> rise_cnt_reg == 4'ha)
        else $error("sequence did not hold ten transfer cycles");
    AST_CS_HIGH_SPAN: assert property ($fell(cs_n) |-> int'(hi_cnt_reg) >= HI_MIN)
        else $error("select high too short for conversion");
    AST_SETUP_GAP: assert property ($rose(xfer_clk) |-> int'(lo_cnt_reg) >= SETUP_MIN)
        else $error("transfer clock too soon after select");
    AST_CS_HIGH_CONV: assert property ($fell(cs_n) |-> cc_hi_reg >= 8'h2c)
        else $error("select high for too few conversion periods");
    AST_ADDR_SETUP: assert property ($rose(xfer_clk) |-> $stable(addr_bit))
        else $error("address bit changed at transfer rise");
endmodule : sadc_asserts

// [verification/serial_adc_control_sequencer_tb_top.sv]
// Testbench joining host and converter ends with a behavioural result model
module serial_adc_control_sequencer_tb_top;
    import sadc_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic start = 1'b0;
    logic [3:0] start_addr = 4'h0;
    logic [11:0] lvl [16];
    logic [11:0] ain_level;
    logic [3:0] chan_sel;
    logic sampling;
    logic conv_busy;
    logic busy;
    logic rd_valid;
    logic [9:0] result;
    logic [9:0] rd_data;
    // Results still held by the converter; -1 marks a self-test code
    int exp_q[$] = '{0};
    int failures = 0;
    int comparisons = 0;
    int samp_cnt = 0;
    int conv_cnt = 0;

    sadc_if link ();
    initial forever #25 clk_sys = ~clk_sys;
    // Conversion clock free running at 400 ns, phase unrelated to clk_sys
    initial begin
        link.conv_clk = 1'b0;
        #37;
        forever #200 link.conv_clk = ~link.conv_clk;
    end
    assign ain_level = lvl[chan_sel];

    sadc_dev i_sadc_dev (.clk_sys(clk_sys), .nrst(nrst), .ce(1'b1), .link(link.dev),
        .ain_level(ain_level), .chan_sel(chan_sel), .sampling(sampling),
        .conv_busy(conv_busy), .result(result));
    sadc_host i_sadc_host (.clk_sys(clk_sys), .nrst(nrst), .ce(1'b1), .link(link.host),
        .start(start), .start_addr(start_addr), .busy(busy), .rd_data(rd_data),
        .rd_valid(rd_valid));
    sadc_asserts i_sadc_asserts (.clk_sys(clk_sys), .nrst(nrst), .cs_n(link.cs_n),
        .addr_bit(link.addr_bit), .xfer_clk(link.xfer_clk), .conv_clk(link.conv_clk),
        .dout(link.dout), .dout_oe(link.dout_oe));

    always @(posedge clk_sys) begin
        if (sampling === 1'b1) samp_cnt++;
        if (conv_busy === 1'b1) conv_cnt++;
    end

    task automatic chk(input bit ok, input string msg);
        comparisons++;
        if (!ok) begin
            failures++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask : chk

    task end_of_test;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : end_of_test

    // One full sequence; the readout must be the previous conversion
    task automatic run(input logic [3:0] a);
        int n;
        int ev;
        logic [9:0] e;
        for (int i = 0; i < 16; i++) begin
            case ($urandom_range(0, 3))
                0: lvl[i] = 12'h800 | 12'($urandom_range(0, 2047));
                1: lvl[i] = 12'h400 | 12'($urandom_range(0, 1023));
                default: lvl[i] = 12'($urandom_range(0, 1023));
            endcase
        end
        samp_cnt = 0;
        conv_cnt = 0;
        start <= 1'b1;
        start_addr <= a;
        @(negedge clk_sys);
        start <= 1'b0;
        n = 0;
        while (rd_valid !== 1'b1 && n < 4000) begin
            @(negedge clk_sys);
            n++;
        end
        chk(n < 4000, "no readout");
        ev = exp_q.pop_front();
        if (ev < 0) chk(rd_data >= 500 && rd_data <= 524, "readout self test");
        else chk(rd_data === 10'(ev), "readout");
        n = 0;
        while (busy === 1'b1 && n < 100) begin
            @(negedge clk_sys);
            n++;
        end
        chk(chan_sel === a, "channel");
        chk(samp_cnt == 120, "sample window");
        chk(conv_cnt >= 344 && conv_cnt <= 420, "conversion time");
        e = lvl[a][11] ? CODE_ZERO : (lvl[a][10] ? CODE_FULL : lvl[a][9:0]);
        if (a == SELF_TEST_CH) chk(result >= 500 && result <= 524, "self test");
        else chk(result === e, "code");
        exp_q.push_back(a == SELF_TEST_CH ? -1 : int'(e));
    endtask : run

    initial begin
        void'($urandom(19970));
        repeat (4) @(negedge clk_sys);
        nrst = 1'b1;
        @(negedge clk_sys);
        chk(link.dout_oe === 1'b0, "output enabled after reset");
        for (int k = 0; k < 16; k++) begin
            run(k < 12 ? 4'(k) : 4'($urandom_range(0, 11)));
        end
        end_of_test;
    end

    // Sixteen sequences need about 9600 cycles
    initial begin
        #(50 * 30000);
        failures++;
        $display("[ERR] %0t watchdog expired", $time);
        end_of_test;
    end
endmodule : serial_adc_control_sequencer_tb_top
